// ==== rtl/filter_regs_pkg.sv ====
// Package for the loop-filter and memory-status register slice.
// Assumes a byte-wide register port driven by the serial host controller.
package filter_regs_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [6:0] OFS_CAP_ONE   = 7'h25;
  localparam logic [6:0] OFS_RES_THREE = 7'h26;
  localparam logic [6:0] OFS_CAP_THREE = 7'h27;
  localparam logic [6:0] OFS_LOCK_WAIT = 7'h2a;
  localparam logic [6:0] OFS_CHECKSUM  = 7'h2f;
  localparam logic [6:0] OFS_CYCLES    = 7'h30;

  localparam logic [2:0] CAP_ONE_RESET   = 3'h0;
  localparam logic [6:0] RES_THREE_RESET = 7'h00;
  localparam logic [2:0] CAP_THREE_RESET = 3'h0;
  localparam logic [1:0] CLOSED_RESET    = 2'h2;
  localparam logic [1:0] OSC_RESET       = 2'h1;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;
  localparam logic [7:0] CYCLE_MAX       = 8'hff;

  // Field positions in the lock-wait register
  localparam int CLOSED_LSB = 2;
  localparam int OSC_LSB    = 0;

  // Settle times in microseconds, indexed by code
  localparam int CLOSED_US [4] = '{150, 300, 500, 2000};
  localparam int OSC_US    [4] = '{20, 400, 4000, 10000};
  localparam int CLOCK_MHZ     = 25;
  localparam int WAIT_W        = 18;

  typedef struct packed {
    logic             write;
    logic             read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [2:0] first_filter_cap_code;
    logic [6:0] third_filter_res_code;
    logic [2:0] third_filter_cap_code;
    logic [1:0] closed_loop_settle_code;
    logic [1:0] oscillator_settle_code;
  } filter_cfg_type;

  typedef struct packed {
    logic       load;
    logic [7:0] stored_checksum;
    logic [7:0] program_cycle_counter;
  } nvm_load_type;
endpackage

// ==== rtl/settle_timer.sv ====
// Settle timer: counts a loaded number of clock cycles, then pulses done.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int WIDTH = 18
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] cycles,
  output var  logic             busy,
  output var  logic             done
);
  logic [WIDTH-1:0] count_q;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("Settle timer width must be at least one bit");
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count_q <= cycles;
        busy    <= 1'b1;
      end
      else if (busy)
      begin
        if (count_q <= WIDTH'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count_q <= count_q - WIDTH'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/filter_status_regs.sv ====
// Loop-filter selection, calibration wait codes and memory status registers.
// Assumes a byte register port from the serial host and a memory controller
// that presents load pulses and erase/program completion pulses.
// What this block does
// - First filter capacitor is a 3-bit code, reset zero, meaning 5 + 50*code pF.
// - Third filter resistor is a 7-bit code, reset zero, every code being a valid choice.
// - Third filter capacitor is a 3-bit code, reset zero, meaning 5*code pF.
// - Closed-loop wait code in bits 3:2 picks 150/300/500/2000 us and resets to 2.
// - Oscillator wait code in bits 1:0 picks 20/400/4000/10000 us and resets to 1.
// - A read-only byte shows the stored checksum, zero until memory is loaded.
// - The cycle counter steps by one after each finished erase/program cycle.
// - The stepped count is handed back to memory so it survives power loss.
// - The counter reloads from memory on each load pulse; a cycle in the same clock steps the loaded value.
// - The counter stops at 255 and further cycles leave it there.
`timescale 1ns/1ps
`default_nettype none
module filter_status_regs
  import filter_regs_pkg::*;
#(
  parameter int CLOSED_CYCLES_MAX = CLOSED_US[3] * CLOCK_MHZ,
  parameter int OSC_CYCLES_MAX    = OSC_US[3] * CLOCK_MHZ
) (
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire filter_regs_pkg::reg_req_type   req,
  output var  logic [filter_regs_pkg::DATA_W-1:0] rdata,
  input  wire filter_regs_pkg::nvm_load_type  nvm_load,
  input  wire logic                           cycle_done,
  input  wire logic                           cal_start,
  output var  filter_regs_pkg::filter_cfg_type cfg,
  output var  logic [7:0]                     count_to_store,
  output var  logic                           count_store,
  output var  logic                           cal_busy,
  output var  logic                           cal_done
);
  import filter_regs_pkg::*;

  // Clamps must fit the settle timer and allow at least one cycle of wait
  if (CLOSED_CYCLES_MAX >= (1 << WAIT_W) || OSC_CYCLES_MAX >= (1 << WAIT_W) ||
      CLOSED_CYCLES_MAX < 1 || OSC_CYCLES_MAX < 1)
  begin : g_bad_wait
    $error("Wait counts do not fit the settle timer");
  end

  filter_cfg_type cfg_q;
  logic [7:0]     checksum_q;
  logic [7:0]     cycles_q;
  logic [7:0]     cycles_d;

  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_OSC    = 2'b01,
    CAL_CLOSED = 2'b10
  } cal_state_type;
  cal_state_type cal_q;

  logic              timer_start;
  logic [WAIT_W-1:0] timer_cycles;
  logic              timer_busy;
  logic              timer_done;

  wire wr = req.write;

  // Configuration fields; only the documented bits are stored
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q.first_filter_cap_code   <= CAP_ONE_RESET;
      cfg_q.third_filter_res_code   <= RES_THREE_RESET;
      cfg_q.third_filter_cap_code   <= CAP_THREE_RESET;
      cfg_q.closed_loop_settle_code <= CLOSED_RESET;
      cfg_q.oscillator_settle_code  <= OSC_RESET;
    end
    else if (wr)
    begin
      case (req.addr)
        OFS_CAP_ONE:   cfg_q.first_filter_cap_code <= req.wdata[2:0];
        OFS_RES_THREE: cfg_q.third_filter_res_code <= req.wdata[6:0];
        OFS_CAP_THREE: cfg_q.third_filter_cap_code <= req.wdata[2:0];
        OFS_LOCK_WAIT:
        begin
          cfg_q.closed_loop_settle_code <= req.wdata[CLOSED_LSB +: 2];
          cfg_q.oscillator_settle_code  <= req.wdata[OSC_LSB +: 2];
        end
        default: ;  // Read-only and unmapped writes are dropped
      endcase
    end
  end

  // Stored checksum follows each memory load
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      checksum_q <= BYTE_ZERO;
    else if (nvm_load.load)
      checksum_q <= nvm_load.stored_checksum;
  end

  // A completed cycle counts up (saturating) and the result is stored back,
  // so the visible value is always the one the memory now holds.
  always_comb
  begin
    cycles_d = cycles_q;
    if (nvm_load.load)
      cycles_d = nvm_load.program_cycle_counter;
    if (cycle_done && cycles_d != CYCLE_MAX)
      cycles_d = cycles_d + 8'h01;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cycles_q       <= BYTE_ZERO;
      count_to_store <= BYTE_ZERO;
      count_store    <= 1'b0;
    end
    else
    begin
      cycles_q       <= cycles_d;
      count_store    <= cycle_done;
      count_to_store <= cycles_d;
    end
  end

  // Calibration: oscillator settle wait, then closed-loop settle wait
  function automatic logic [WAIT_W-1:0] us_to_cycles(input int us, input int cap);
    int c;
    c = us * CLOCK_MHZ;
    if (c > cap)
      c = cap;
    if (c < 1)
      c = 1;
    return c[WAIT_W-1:0];
  endfunction

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_q        <= CAL_IDLE;
      timer_start  <= 1'b0;
      timer_cycles <= '0;
      cal_done     <= 1'b0;
    end
    else
    begin
      timer_start <= 1'b0;
      cal_done    <= 1'b0;
      case (cal_q)
        CAL_IDLE:
          if (cal_start)
          begin
            timer_cycles <= us_to_cycles(OSC_US[cfg_q.oscillator_settle_code],
                                         OSC_CYCLES_MAX);
            timer_start  <= 1'b1;
            cal_q        <= CAL_OSC;
          end
        CAL_OSC:
          if (timer_done)
          begin
            timer_cycles <= us_to_cycles(CLOSED_US[cfg_q.closed_loop_settle_code],
                                         CLOSED_CYCLES_MAX);
            timer_start  <= 1'b1;
            cal_q        <= CAL_CLOSED;
          end
        CAL_CLOSED:
          if (timer_done)
          begin
            cal_done <= 1'b1;
            cal_q    <= CAL_IDLE;
          end
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end

  settle_timer #(
    .WIDTH (WAIT_W)
  ) u_timer (
    .clock  (clock),
    .nrst   (nrst),
    .start  (timer_start),
    .cycles (timer_cycles),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cal_busy <= 1'b0;
    else
      cal_busy <= (cal_q != CAL_IDLE) || timer_busy;
  end

  // Registered read data; reserved bits return zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= BYTE_ZERO;
    else if (req.read)
    begin
      case (req.addr)
        OFS_CAP_ONE:   rdata <= {5'h0, cfg_q.first_filter_cap_code};
        OFS_RES_THREE: rdata <= {1'h0, cfg_q.third_filter_res_code};
        OFS_CAP_THREE: rdata <= {5'h0, cfg_q.third_filter_cap_code};
        OFS_LOCK_WAIT: rdata <= {4'h0, cfg_q.closed_loop_settle_code,
                                 cfg_q.oscillator_settle_code};
        OFS_CHECKSUM:  rdata <= checksum_q;
        OFS_CYCLES:    rdata <= cycles_q;
        default:       rdata <= BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cfg <= '{first_filter_cap_code: CAP_ONE_RESET, third_filter_res_code: RES_THREE_RESET,
               third_filter_cap_code: CAP_THREE_RESET, closed_loop_settle_code: CLOSED_RESET,
               oscillator_settle_code: OSC_RESET};
    else
      cfg <= cfg_q;
  end
endmodule
`default_nettype wire

// ==== bench/filter_status_regs_chk.sv ====
// Checker for the filter and memory status register slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module filter_status_regs_chk
  import filter_regs_pkg::*;
(
  input wire logic                            clock,
  input wire logic                            nrst,
  input wire filter_regs_pkg::reg_req_type    req,
  input wire logic [7:0]                      rdata,
  input wire filter_regs_pkg::nvm_load_type   nvm_load,
  input wire logic                            cycle_done,
  input wire logic                            cal_start,
  input wire filter_regs_pkg::filter_cfg_type cfg,
  input wire logic [7:0]                      count_to_store,
  input wire logic                            count_store,
  input wire logic                            cal_busy,
  input wire logic                            cal_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_store_pulse: assert property (cycle_done |=> count_store)
    else $error("store pulse missing");
  a_store_cause: assert property (count_store |-> $past(cycle_done))
    else $error("store pulse without cycle");
  a_load_step: assert property (nvm_load.load && cycle_done
    && nvm_load.program_cycle_counter != CYCLE_MAX
    |=> count_to_store == $past(nvm_load.program_cycle_counter) + 8'h01)
    else $error("load with cycle not stepped");
  // A load between two cycles moves the counter, so only back-to-back cycles
  a_count_sat: assert property (count_store && cycle_done && !nvm_load.load
    && count_to_store == CYCLE_MAX |=> count_to_store == CYCLE_MAX)
    else $error("count passed its ceiling");
  a_lock_write: assert property (req.write && req.addr == OFS_LOCK_WAIT |-> ##2
    {cfg.closed_loop_settle_code, cfg.oscillator_settle_code} == $past(req.wdata[3:0], 2))
    else $error("wait codes not applied");
  a_cap_write: assert property (req.write && req.addr == OFS_CAP_ONE |-> ##2
    cfg.first_filter_cap_code == $past(req.wdata[2:0], 2))
    else $error("capacitor code not applied");
  a_cal_busy: assert property (cal_start && !cal_busy |-> ##2 cal_busy)
    else $error("calibration not busy");
  a_done_after: assert property (cal_done |-> $past(cal_busy))
    else $error("done without wait");
  a_zero_unmapped: assert property (req.read && req.addr == 7'h7f |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_zero: assert property (req.read && req.addr == OFS_CAP_THREE |=> rdata[7:3] == 5'h00)
    else $error("reserved bits not zero");
  cover property (cal_done);
  cover property (count_store && count_to_store == CYCLE_MAX);
  cover property (nvm_load.load && cycle_done);
endmodule
bind filter_status_regs filter_status_regs_chk chk (.clock(clock), .nrst(nrst), .req(req),
  .rdata(rdata), .nvm_load(nvm_load), .cycle_done(cycle_done), .cal_start(cal_start),
  .cfg(cfg), .count_to_store(count_to_store), .count_store(count_store),
  .cal_busy(cal_busy), .cal_done(cal_done));
`default_nettype wire

// ==== bench/reg_host.sv ====
// Host model: single byte register writes and reads.
// Assumes one request at a time, launched just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module reg_host
  import filter_regs_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic [7:0]                   rdata,
  output var  filter_regs_pkg::reg_req_type req
);
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    #1;
    // Released lines flip so stale data cannot pass for fresh
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1;
    d = rdata;
    req = '{1'b0, 1'b0, ~a, 8'hff};
  endtask
endmodule
`default_nettype wire

// ==== bench/pll_filter_and_nvm_status_regs_bench.sv ====
// Bench for the filter and memory status register slice.
// Assumes wait clamps of 600 and 4000 cycles: code 0 runs unclamped, others stay brief.
`timescale 1ns/1ps
`default_nettype none
module pll_filter_and_nvm_status_regs_bench;
  import filter_regs_pkg::*;
  localparam int  OSC_CAP = 600;
  localparam int  CLOSED_CAP = 4000;
  logic           clock = 0, nrst = 0, cycle_done = 0, cal_start = 0;
  nvm_load_type   nvm_load = '0;
  reg_req_type    req;
  filter_cfg_type cfg;
  logic [7:0]     rdata, count_to_store, v;
  logic           count_store, cal_busy, cal_done;
  int             bad_count = 0, checks = 0;
  logic [6:0]     regs [7] = '{7'h25, 7'h26, 7'h27, 7'h2a, 7'h2f, 7'h30, 7'h7f};
  logic [7:0]     rmask [7] = '{8'h07, 8'h7f, 8'h07, 8'h0f, 8'h00, 8'h00, 8'h00};
  filter_status_regs #(.CLOSED_CYCLES_MAX(CLOSED_CAP), .OSC_CYCLES_MAX(OSC_CAP)) DUT (
    .clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .nvm_load(nvm_load),
    .cycle_done(cycle_done), .cal_start(cal_start), .cfg(cfg),
    .count_to_store(count_to_store), .count_store(count_store),
    .cal_busy(cal_busy), .cal_done(cal_done));
  reg_host host (.clock(clock), .rdata(rdata), .req(req));
  initial forever #20 clock = ~clock;
  // Wide enough for the whole 17-bit configuration struct
  task automatic check(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse_done(input int n, input logic ld, input logic [7:0] e);
    tick(1);
    cycle_done = 1;
    nvm_load.load = ld;
    tick(n);
    cycle_done = 0;
    nvm_load.load = 0;
    check("store", count_store, 1);
    check("to_store", count_to_store, e);
    host.rd(OFS_CYCLES, v);
    check("count", v, e);
  endtask
  task automatic t_regs;
    check("cfg", cfg, 17'h0_0009);
    foreach (regs[i])
    begin
      host.rd(regs[i], v);
      check("reset", v, i == 3 ? 8'h09 : 8'h00);
    end
    foreach (regs[i])
      host.wr(regs[i], 8'hff);
    foreach (regs[i])
    begin
      host.rd(regs[i], v);
      check("write", v, rmask[i]);
    end
    check("cfg", cfg, 17'h1_ffff);
    host.wr(OFS_RES_THREE, 8'h14);
    host.rd(OFS_RES_THREE, v);
    check("res", v, 8'h14);
  endtask
  task automatic t_nvm;
    tick(1);
    nvm_load = '{1'b1, 8'ha5, 8'hfd};
    tick(1);
    nvm_load = '{1'b0, 8'h5a, 8'h10};
    host.rd(OFS_CHECKSUM, v);
    check("checksum", v, 8'ha5);
    host.rd(OFS_CYCLES, v);
    check("count", v, 8'hfd);
    pulse_done(1, 0, 8'hfe);
    pulse_done(1, 0, 8'hff);
    pulse_done(2, 0, 8'hff);
    pulse_done(1, 1, 8'h11);
    host.rd(OFS_CHECKSUM, v);
    check("checksum", v, 8'h5a);
  endtask
  task automatic t_cal;
    int n;
    int want;
    for (int c = 0; c < 4; c++)
    begin
      // Both waits in cycles, clamped as configured, plus three register stages
      want = (OSC_US[c] * CLOCK_MHZ < OSC_CAP ? OSC_US[c] * CLOCK_MHZ : OSC_CAP)
           + (CLOSED_US[c] * CLOCK_MHZ < CLOSED_CAP ? CLOSED_US[c] * CLOCK_MHZ : CLOSED_CAP)
           + 3;
      host.wr(OFS_LOCK_WAIT, 8'(c * 5));
      tick(2);
      cal_start = 1;
      tick(1);
      cal_start = 0;
      tick(1);
      check("busy", cal_busy, 1);
      n = 0;
      while (cal_done !== 1'b1 && n < 6000)
      begin
        tick(1);
        n++;
      end
      check("done", cal_done, 1);
      check("wait", n, want);
    end
    host.wr(OFS_LOCK_WAIT, 8'h09);
  endtask
  initial
  begin
    tick(20);
    nrst = 1;
    t_regs;
    t_nvm;
    t_cal;
    test_done;
  end
  initial
  begin
    #(40 * 30000);
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
